// [bench/sad_cfg_model.sv]
// configuration source: management controls and aperture as boot code leaves them
// assumes the decoder treats these as static levels
`timescale 1ns/1ps
`default_nettype none
module sad_cfg_model (
  // management controls
  output logic mgmt_open_out,
  output logic mgmt_close_out,
  // aperture
  output logic [31:0] aperture_base_out,
  output logic [31:0] aperture_size_out
);
  // open and close never both high; both low keeps mode-driven access
  assign mgmt_open_out = 1'h0;
  assign mgmt_close_out = 1'h0;
  // aperture far above the legacy low region, so no entry lands there
  assign aperture_base_out = 32'hD0000000;
  assign aperture_size_out = 32'h01000000;
endmodule
`default_nettype wire

// [bench/sad_decoder_test.sv]
// self-checking bench for the system address decoder
// assumes one answer exactly one cycle after each request
`timescale 1ns/1ps
`default_nettype none
module sad_decoder_test;
  localparam logic [31:0] nc = 32'hFFFFFFFF;
  localparam sad_pkg::sad_src_t s_cpu = sad_pkg::SAD_SRC_CPU;
  localparam sad_pkg::sad_src_t s_ha = sad_pkg::SAD_SRC_HUBA;
  localparam sad_pkg::sad_src_t s_hb = sad_pkg::SAD_SRC_HUBB;
  localparam sad_pkg::sad_src_t s_fr = sad_pkg::SAD_SRC_GFX_FRAME;
  localparam sad_pkg::sad_src_t s_pp = sad_pkg::SAD_SRC_GFX_PIPE;
  localparam sad_pkg::sad_tgt_t t_no = sad_pkg::SAD_TGT_NONE;
  localparam sad_pkg::sad_tgt_t t_dr = sad_pkg::SAD_TGT_DRAM;
  localparam sad_pkg::sad_tgt_t t_ha = sad_pkg::SAD_TGT_HUBA;
  localparam sad_pkg::sad_tgt_t t_hb = sad_pkg::SAD_TGT_HUBB;
  localparam sad_pkg::sad_tgt_t t_gx = sad_pkg::SAD_TGT_GFX;
  localparam sad_pkg::sad_tgt_t t_cf = sad_pkg::SAD_TGT_CFG;
  localparam sad_pkg::sad_tgt_t t_ro = sad_pkg::SAD_TGT_ROM;
  localparam sad_pkg::sad_rsp_t k_ok = sad_pkg::SAD_RSP_OK;
  localparam sad_pkg::sad_rsp_t k_ab = sad_pkg::SAD_RSP_ABORT;
  localparam sad_pkg::sad_rsp_t k_dp = sad_pkg::SAD_RSP_DROP;
  localparam sad_pkg::sad_rsp_t k_un = sad_pkg::SAD_RSP_UNCLAIMED;
  logic mclk_in = 1'h0, rst_b_in = 1'h0, req_valid_in = 1'h0, req_is_io_in = 1'h0;
  logic req_is_special_in = 1'h0, req_write_in = 1'h0, req_above_4g_in = 1'h0;
  logic io_wrap_address_bit_in = 1'h0, system_management_mode_in = 1'h0, flag_clear_in = 1'h0;
  logic top_mgmt_segment_en_in = 1'h1, high_mgmt_segment_en_in = 1'h1, compat_mgmt_en_in = 1'h1;
  logic gfx_legacy_display_en_in = 1'h1, hubb_en_in = 1'h1;
  sad_pkg::sad_src_t req_src_in = sad_pkg::SAD_SRC_CPU;
  logic [7:0] req_be_in = 8'hFF;
  logic [31:0] req_addr_in = 32'h0, top_of_memory_in = 32'h08000000, top_segment_size_in = 32'h00100000;
  logic [31:0] gfx_mem_base_in = 32'hE0000000, gfx_mem_limit_in = 32'hE0FFFFFF;
  logic [31:0] gfx_prefetch_base_in = 32'hE1000000, gfx_prefetch_limit_in = 32'hE1FFFFFF;
  logic [31:0] hubb_mem_base_in = 32'hF0000000, hubb_mem_limit_in = 32'hF0FFFFFF;
  logic [sad_pkg::PAM_N-1:0] compat_range_attribute_rd_in = 13'h0001, compat_range_attribute_wr_in = 13'h0002;
  logic [15:0] gfx_io_window_base_in = 16'h1000, gfx_io_window_limit_in = 16'h1FFF;
  logic [15:0] hubb_io_window_base_in = 16'h2000, hubb_io_window_limit_in = 16'h2FFF;
  wire logic mgmt_open_in, mgmt_close_in;
  wire logic [31:0] aperture_base_in, aperture_size_in;
  logic rsp_valid_out, rsp_snoop_out, rsp_posted_out, invalid_graphics_access_flag_out;
  sad_pkg::sad_tgt_t rsp_tgt_out;
  sad_pkg::sad_rsp_t rsp_kind_out;
  logic [31:0] rsp_addr_out;
  logic [7:0] rsp_be_out;
  int n_mismatch = 0, num_checks = 0, cyc = 0;

  sad_cfg_model cfg (.mgmt_open_out(mgmt_open_in), .mgmt_close_out(mgmt_close_in),
    .aperture_base_out(aperture_base_in), .aperture_size_out(aperture_size_in));
  sad_decoder dut (.*);

  initial
  begin
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // hangs are cut short well above the roughly 90 cycles the tests need
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 400)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    begin
      num_checks++;
      if (g !== e)
      begin
        n_mismatch++;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // f bits: special, above 4g, wrap, mgmt mode, io, write; returns 1 ns after the answer edge
  task automatic rq(input sad_pkg::sad_src_t s, input logic [5:0] f, input logic [31:0] a,
    input sad_pkg::sad_tgt_t et, input sad_pkg::sad_rsp_t ek, input logic [31:0] ea);
    begin
      @(posedge mclk_in);
      req_src_in <= s;
      {req_is_special_in, req_above_4g_in, io_wrap_address_bit_in, system_management_mode_in,
        req_is_io_in, req_write_in} <= f;
      req_addr_in <= a;
      req_valid_in <= 1'h1;
      @(posedge mclk_in);
      req_valid_in <= 1'h0;
      #1;
      cmp(rsp_valid_out, 1'h1);
      cmp(rsp_tgt_out, et);
      cmp(rsp_kind_out, ek);
      if (ea !== nc)
        cmp(rsp_addr_out, ea);
    end
  endtask

  task automatic t_mgmt;
    begin
      rq(s_cpu, 6'h04, 32'hFFEA1234, t_dr, k_ok, 32'h000A1234);
      rq(s_cpu, 6'h01, 32'hFFEA1234, t_dr, k_ok, 32'h00000000);
      cmp(rsp_be_out, 8'h00);
      rq(s_cpu, 6'h04, 32'h07F00010, t_dr, k_ok, 32'h07F00010);
      rq(s_cpu, 6'h04, 32'h000B0000, t_dr, k_ok, 32'h000B0000);
      $display("test mgmt done");
    end
  endtask

  task automatic t_io;
    begin
      rq(s_cpu, 6'h02, 32'h00000CF8, t_cf, k_ok, nc);
      rq(s_cpu, 6'h02, 32'h00000FFF, t_ha, k_ok, 32'h00000FFF);
      rq(s_cpu, 6'h02, 32'h00001000, t_gx, k_ok, 32'h00001000);
      rq(s_cpu, 6'h02, 32'h00002FFF, t_hb, k_ok, 32'h00002FFF);
      rq(s_cpu, 6'h0A, 32'h0000FFFD, t_ha, k_ok, 32'h0001FFFD);
      rq(s_cpu, 6'h03, 32'h000001F0, t_ha, k_ok, 32'h000001F0);
      cmp(rsp_posted_out, 1'h0);
      rq(s_cpu, 6'h03, 32'h000001F8, t_ha, k_ok, 32'h000001F8);
      cmp(rsp_posted_out, 1'h1);
      $display("test io done");
    end
  endtask

  task automatic t_hub;
    begin
      rq(s_ha, 6'h02, 32'h00000100, t_no, k_un, nc);
      rq(s_hb, 6'h02, 32'h00000100, t_no, k_ab, nc);
      rq(s_ha, 6'h00, 32'h00100000, t_dr, k_ok, 32'h00100000);
      rq(s_ha, 6'h10, 32'h00100000, t_no, k_ab, nc);
      rq(s_ha, 6'h11, 32'h00100000, t_no, k_dp, nc);
      rq(s_hb, 6'h01, 32'hE0000010, t_gx, k_ok, 32'hE0000010);
      rq(s_hb, 6'h00, 32'h07F00010, t_no, k_ab, nc);
      rq(s_hb, 6'h00, 32'hF8000000, t_no, k_ab, nc);
      $display("test hub done");
    end
  endtask

  task automatic t_gfx;
    begin
      rq(s_fr, 6'h00, 32'h00200000, t_dr, k_ok, 32'h00200000);
      cmp(rsp_snoop_out, 1'h0);
      rq(s_fr, 6'h00, 32'hD0000000, t_dr, k_ok, nc);
      rq(s_fr, 6'h01, 32'hF8000000, t_no, k_un, nc);
      rq(s_fr, 6'h02, 32'h00001000, t_no, k_un, nc);
      rq(s_fr, 6'h20, 32'h00000000, t_no, k_un, nc);
      rq(s_fr, 6'h00, 32'h000C4000, t_no, k_un, nc);
      rq(s_fr, 6'h00, 32'h000C0000, t_dr, k_ok, 32'h000C0000);
      rq(s_fr, 6'h01, 32'h000C0000, t_no, k_un, nc);
      rq(s_fr, 6'h01, 32'h000C4000, t_dr, k_ok, 32'h000C4000);
      rq(s_pp, 6'h00, 32'h00300000, t_dr, k_ok, 32'h00300000);
      cmp(rsp_snoop_out, 1'h0);
      cmp(invalid_graphics_access_flag_out, 1'h0);
      rq(s_pp, 6'h00, 32'hF8000000, t_dr, k_ok, 32'h00000000);
      cmp(invalid_graphics_access_flag_out, 1'h1);
      rq(s_pp, 6'h01, 32'hF8000000, t_no, k_dp, nc);
      @(posedge mclk_in);
      flag_clear_in <= 1'h1;
      @(posedge mclk_in);
      flag_clear_in <= 1'h0;
      #1;
      cmp(invalid_graphics_access_flag_out, 1'h0);
      $display("test gfx done");
    end
  endtask

  task automatic t_shadow;
    begin
      rq(s_cpu, 6'h00, 32'h000C0000, t_dr, k_ok, 32'h000C0000);
      rq(s_cpu, 6'h01, 32'h000C0000, t_ro, k_ok, nc);
      rq(s_cpu, 6'h00, 32'h000C4000, t_ro, k_ok, nc);
      rq(s_cpu, 6'h01, 32'h000C4000, t_dr, k_ok, 32'h000C4000);
      $display("test shadow done");
    end
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'h1;
    @(posedge mclk_in);
    t_mgmt();
    t_io();
    t_hub();
    t_gfx();
    t_shadow();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [core/sad_decoder.sv]
// system address decoder: registers one request, answers one cycle later
// assumes requests from the same clock domain, configuration as static inputs
// What this block does
// - high management window remaps to compatible dram range in management mode
// - top segment window, and compatible window when visible, reach dram at the issued address
// - non-management high window access goes to address zero, writes masked
// - shadow blocks route reads and writes to rom or dram independently
// - processor i/o goes to a link or graphics, except config ports
// - i/o address forwarded untranslated including the wrap bit
// - other i/o goes to a hub link; disk controller writes not posted
// - i/o cycles from graphics or hub links are never claimed
// - inclusive base/limit compare selects graphics or second hub i/o
// - first hub accepts dram, graphics window writes, aperture, display writes
// - first hub above 4 GB: reads abort, writes discarded
// - second hub accepts the same set of ranges as the first
// - second hub out-of-range memory and all its i/o abort
// - framed graphics claims only dram or aperture memory cycles
// - framed graphics write to non-writable compat range left unclaimed
// - framed graphics read to compat range claimed only if readable
// - graphics i/o, config and special cycles get no response
// - graphics cycles to dram are not snooped
// - pipelined read outside memory goes to zero and flags; write dropped
`timescale 1ns/1ps
`default_nettype none
module sad_decoder (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // request
  input wire logic req_valid_in,
  input wire sad_pkg::sad_src_t req_src_in,
  input wire logic req_is_io_in,
  input wire logic req_is_special_in,
  input wire logic req_write_in,
  input wire logic req_above_4g_in,
  input wire logic [31:0] req_addr_in,
  input wire logic io_wrap_address_bit_in,
  input wire logic system_management_mode_in,
  input wire logic [7:0] req_be_in,
  // memory map
  input wire logic [31:0] top_of_memory_in,
  input wire logic [31:0] top_segment_size_in,
  input wire logic top_mgmt_segment_en_in,
  input wire logic high_mgmt_segment_en_in,
  input wire logic compat_mgmt_en_in,
  input wire logic mgmt_open_in,
  input wire logic mgmt_close_in,
  input wire logic [31:0] gfx_mem_base_in,
  input wire logic [31:0] gfx_mem_limit_in,
  input wire logic [31:0] gfx_prefetch_base_in,
  input wire logic [31:0] gfx_prefetch_limit_in,
  input wire logic [31:0] aperture_base_in,
  input wire logic [31:0] aperture_size_in,
  input wire logic [31:0] hubb_mem_base_in,
  input wire logic [31:0] hubb_mem_limit_in,
  input wire logic gfx_legacy_display_en_in,
  input wire logic [sad_pkg::PAM_N-1:0] compat_range_attribute_rd_in,
  input wire logic [sad_pkg::PAM_N-1:0] compat_range_attribute_wr_in,
  // i/o windows
  input wire logic [15:0] gfx_io_window_base_in,
  input wire logic [15:0] gfx_io_window_limit_in,
  input wire logic [15:0] hubb_io_window_base_in,
  input wire logic [15:0] hubb_io_window_limit_in,
  input wire logic hubb_en_in,
  // status clear
  input wire logic flag_clear_in,
  // answer
  output logic rsp_valid_out,
  output sad_pkg::sad_tgt_t rsp_tgt_out,
  output sad_pkg::sad_rsp_t rsp_kind_out,
  output logic [31:0] rsp_addr_out,
  output logic [7:0] rsp_be_out,
  output logic rsp_snoop_out,
  output logic rsp_posted_out,
  output logic invalid_graphics_access_flag_out
);
  sad_pkg::sad_st_t st_ff;
  sad_pkg::sad_tgt_t nxt_tgt;
  sad_pkg::sad_rsp_t nxt_kind;
  logic [31:0] nxt_addr;
  logic [7:0] nxt_be;
  logic nxt_snoop;
  logic nxt_posted;
  logic nxt_flag_set;
  sad_pkg::sad_tgt_t rsp_tgt_ff;
  sad_pkg::sad_rsp_t rsp_kind_ff;
  logic [31:0] rsp_addr_ff;
  logic [7:0] rsp_be_ff;
  logic rsp_snoop_ff;
  logic rsp_posted_ff;
  logic flag_ff;
  logic high_hit;
  logic seg_hit;
  logic compat_hit;
  logic dram_hit;
  logic pam_hit;
  logic gfxm_hit;
  logic gfxp_hit;
  logic hubbm_hit;
  logic aper_hit;
  logic gfxwin_hit;
  logic compat_mgmt_vis;
  logic [31:0] seg_base;
  logic [31:0] aper_limit;
  logic [3:0] pam_idx;
  logic pam_rd;
  logic pam_wr;
  logic mgmt_space;
  sad_pkg::sad_tgt_t io_tgt;
  logic [16:0] io_fwd;

  // attribute index for a shadow block
  function automatic logic [3:0] pam_index(input logic [31:0] a);
    logic [3:0] idx;
    idx = 4'(a[19:sad_pkg::PAM_SHIFT] - 6'(sad_pkg::PAM_LO[19:sad_pkg::PAM_SHIFT])) + sad_pkg::PAM_BASE_IDX;
    // the last attribute covers the whole top segment, so higher blocks fold onto it
    pam_index = (idx > 4'(sad_pkg::PAM_N - 1)) ? 4'(sad_pkg::PAM_N - 1) : idx;
  endfunction

  assign seg_base = top_of_memory_in - top_segment_size_in;
  assign aper_limit = aperture_base_in + aperture_size_in - 32'h00000001;
  sad_range_cmp u_seg (.base_in(seg_base), .limit_in(top_of_memory_in - 32'h00000001),
    .en_in(top_mgmt_segment_en_in), .addr_in(req_addr_in), .hit_out(seg_hit));
  sad_range_cmp u_high (.base_in(sad_pkg::HIGH_LO), .limit_in(sad_pkg::HIGH_HI),
    .en_in(high_mgmt_segment_en_in), .addr_in(req_addr_in), .hit_out(high_hit));
  sad_range_cmp u_comp (.base_in(sad_pkg::COMPAT_LO), .limit_in(sad_pkg::COMPAT_HI),
    .en_in(1'b1), .addr_in(req_addr_in), .hit_out(compat_hit));
  sad_range_cmp u_pam (.base_in(sad_pkg::PAM_LO), .limit_in(sad_pkg::PAM_HI),
    .en_in(1'b1), .addr_in(req_addr_in), .hit_out(pam_hit));
  sad_range_cmp u_gfxm (.base_in(gfx_mem_base_in), .limit_in(gfx_mem_limit_in),
    .en_in(1'b1), .addr_in(req_addr_in), .hit_out(gfxm_hit));
  sad_range_cmp u_gfxp (.base_in(gfx_prefetch_base_in), .limit_in(gfx_prefetch_limit_in),
    .en_in(1'b1), .addr_in(req_addr_in), .hit_out(gfxp_hit));
  sad_range_cmp u_hubbm (.base_in(hubb_mem_base_in), .limit_in(hubb_mem_limit_in),
    .en_in(hubb_en_in), .addr_in(req_addr_in), .hit_out(hubbm_hit));
  sad_range_cmp u_aper (.base_in(aperture_base_in), .limit_in(aper_limit),
    .en_in(aperture_size_in != sad_pkg::ZERO_ADDR), .addr_in(req_addr_in), .hit_out(aper_hit));
  sad_io_route u_io (
    .io_addr_in(req_addr_in[15:0]),
    .io_wrap_address_bit_in(io_wrap_address_bit_in),
    .gfx_io_window_base_in(gfx_io_window_base_in),
    .gfx_io_window_limit_in(gfx_io_window_limit_in),
    .hubb_io_window_base_in(hubb_io_window_base_in),
    .hubb_io_window_limit_in(hubb_io_window_limit_in),
    .hubb_en_in(hubb_en_in),
    .tgt_out(io_tgt),
    .fwd_addr_out(io_fwd)
  );

  assign gfxwin_hit = gfxm_hit || gfxp_hit;
  // dram is below top of memory, excluding the shadow blocks and the compat display hole
  assign dram_hit = !req_above_4g_in && (req_addr_in < top_of_memory_in) && !compat_hit && !pam_hit;
  assign pam_idx = pam_index(req_addr_in);
  assign pam_rd = compat_range_attribute_rd_in[pam_idx];
  assign pam_wr = compat_range_attribute_wr_in[pam_idx];
  // close hides compat dram from data accesses; open exposes it; both together exposes it, open wins
  assign compat_mgmt_vis = compat_mgmt_en_in && (mgmt_open_in || (system_management_mode_in && !mgmt_close_in));
  assign mgmt_space = seg_hit || high_hit || (compat_hit && compat_mgmt_en_in);

  always_comb
  begin
    nxt_tgt = sad_pkg::SAD_TGT_HUBA;
    nxt_kind = sad_pkg::SAD_RSP_OK;
    nxt_addr = req_addr_in;
    nxt_be = req_be_in;
    nxt_snoop = 1'b0;
    nxt_posted = req_write_in;
    nxt_flag_set = 1'b0;
    unique case (req_src_in)
      sad_pkg::SAD_SRC_CPU:
      begin
        if (req_is_io_in)
        begin
          nxt_tgt = io_tgt;
          nxt_addr = {15'h0000, io_fwd};
          // writes to the disk controller must complete before the processor moves on
          nxt_posted = req_write_in && !((req_addr_in[15:0] >= sad_pkg::IDE_IO_LO)
            && (req_addr_in[15:0] <= sad_pkg::IDE_IO_HI));
        end
        else if (high_hit)
        begin
          nxt_tgt = sad_pkg::SAD_TGT_DRAM;
          if (system_management_mode_in)
            nxt_addr = req_addr_in - sad_pkg::HIGH_TO_COMPAT;
          else
          begin
            nxt_addr = sad_pkg::ZERO_ADDR;
            nxt_be = req_write_in ? 8'h00 : req_be_in;
          end
        end
        else if (seg_hit)
          nxt_tgt = sad_pkg::SAD_TGT_DRAM;
        else if (compat_hit)
          nxt_tgt = compat_mgmt_vis ? sad_pkg::SAD_TGT_DRAM : sad_pkg::SAD_TGT_HUBA;
        else if (pam_hit)
        begin
          if (req_write_in)
            nxt_tgt = pam_wr ? sad_pkg::SAD_TGT_DRAM : sad_pkg::SAD_TGT_ROM;
          else
            nxt_tgt = pam_rd ? sad_pkg::SAD_TGT_DRAM : sad_pkg::SAD_TGT_ROM;
        end
        else if (aper_hit || dram_hit)
        begin
          nxt_tgt = sad_pkg::SAD_TGT_DRAM;
          nxt_snoop = 1'b1;
        end
        else if (gfxwin_hit)
          nxt_tgt = sad_pkg::SAD_TGT_GFX;
        else if (hubbm_hit)
          nxt_tgt = sad_pkg::SAD_TGT_HUBB;
      end
      sad_pkg::SAD_SRC_HUBA, sad_pkg::SAD_SRC_HUBB:
      begin
        nxt_snoop = 1'b1;
        if (req_is_io_in || req_is_special_in)
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = (req_src_in == sad_pkg::SAD_SRC_HUBB) ? sad_pkg::SAD_RSP_ABORT
            : sad_pkg::SAD_RSP_UNCLAIMED;
        end
        else if ((req_src_in == sad_pkg::SAD_SRC_HUBA) && req_above_4g_in)
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = req_write_in ? sad_pkg::SAD_RSP_DROP : sad_pkg::SAD_RSP_ABORT;
        end
        else if (!req_above_4g_in && (aper_hit || (dram_hit && !mgmt_space)))
          nxt_tgt = sad_pkg::SAD_TGT_DRAM;
        else if (!req_above_4g_in && req_write_in && (gfxwin_hit || (compat_hit && gfx_legacy_display_en_in)))
          nxt_tgt = sad_pkg::SAD_TGT_GFX;
        else
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = sad_pkg::SAD_RSP_ABORT;
        end
      end
      sad_pkg::SAD_SRC_GFX_FRAME:
      begin
        if (req_is_io_in || req_is_special_in)
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = sad_pkg::SAD_RSP_UNCLAIMED;
        end
        else if (pam_hit && !(req_write_in ? pam_wr : pam_rd))
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = sad_pkg::SAD_RSP_UNCLAIMED;
        end
        else if (!req_above_4g_in && (aper_hit || pam_hit || (dram_hit && !mgmt_space)))
          nxt_tgt = sad_pkg::SAD_TGT_DRAM;
        else
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = sad_pkg::SAD_RSP_UNCLAIMED;
        end
      end
      sad_pkg::SAD_SRC_GFX_PIPE:
      begin
        nxt_tgt = sad_pkg::SAD_TGT_DRAM;
        // masters keep to dram or aperture; anything else is treated as invalid
        if (req_is_io_in || req_is_special_in)
        begin
          nxt_tgt = sad_pkg::SAD_TGT_NONE;
          nxt_kind = sad_pkg::SAD_RSP_UNCLAIMED;
        end
        else if (req_above_4g_in || !(aper_hit || pam_hit || (dram_hit && !mgmt_space)))
        begin
          if (req_write_in)
          begin
            nxt_tgt = sad_pkg::SAD_TGT_NONE;
            nxt_kind = sad_pkg::SAD_RSP_DROP;
          end
          else
          begin
            nxt_addr = sad_pkg::ZERO_ADDR;
            nxt_flag_set = 1'b1;
          end
        end
      end
      default:
      begin
        nxt_tgt = sad_pkg::SAD_TGT_NONE;
        nxt_kind = sad_pkg::SAD_RSP_UNCLAIMED;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st_ff <= sad_pkg::SAD_ST_IDLE;
    else if (req_valid_in)
      st_ff <= sad_pkg::SAD_ST_DEC;
    else
      st_ff <= sad_pkg::SAD_ST_IDLE;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rsp_tgt_ff <= sad_pkg::SAD_TGT_NONE;
      rsp_kind_ff <= sad_pkg::SAD_RSP_OK;
      rsp_addr_ff <= sad_pkg::ZERO_ADDR;
      rsp_be_ff <= 8'h00;
      rsp_snoop_ff <= 1'b0;
      rsp_posted_ff <= 1'b0;
    end
    else
    begin
      if (req_valid_in)
      begin
        rsp_tgt_ff <= nxt_tgt;
        rsp_kind_ff <= nxt_kind;
        rsp_addr_ff <= nxt_addr;
        rsp_be_ff <= nxt_be;
        rsp_snoop_ff <= nxt_snoop;
        rsp_posted_ff <= nxt_posted;
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      flag_ff <= 1'b0;
    else if (req_valid_in && nxt_flag_set)
      flag_ff <= 1'b1;
    else if (flag_clear_in)
      flag_ff <= 1'b0;
  end

  assign rsp_valid_out = (st_ff == sad_pkg::SAD_ST_DEC);
  assign rsp_tgt_out = rsp_tgt_ff;
  assign rsp_kind_out = rsp_kind_ff;
  assign rsp_addr_out = rsp_addr_ff;
  assign rsp_be_out = rsp_be_ff;
  assign rsp_snoop_out = rsp_snoop_ff;
  assign rsp_posted_out = rsp_posted_ff;
  assign invalid_graphics_access_flag_out = flag_ff;

  sequence s_high_nonmgmt_wr;
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_CPU) && !req_is_io_in && high_hit
      && !system_management_mode_in && req_write_in;
  endsequence
  sequence s_zero_masked;
    rsp_valid_out && (rsp_addr_out == sad_pkg::ZERO_ADDR) && (rsp_be_out == 8'h00);
  endsequence

  a_high_remap: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_CPU) && !req_is_io_in && high_hit && system_management_mode_in
    |=> rsp_addr_out == $past(req_addr_in) - sad_pkg::HIGH_TO_COMPAT && rsp_tgt_out == sad_pkg::SAD_TGT_DRAM)
    else $error("high window not remapped");
  a_high_invalid: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_high_nonmgmt_wr |=> s_zero_masked)
    else $error("invalid high access not zeroed");
  a_seg_same: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_CPU) && !req_is_io_in && seg_hit && !high_hit
    |=> rsp_addr_out == $past(req_addr_in))
    else $error("segment address changed");
  a_io_cfg: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_CPU) && req_is_io_in
    |=> rsp_tgt_out inside {sad_pkg::SAD_TGT_HUBA, sad_pkg::SAD_TGT_HUBB, sad_pkg::SAD_TGT_GFX, sad_pkg::SAD_TGT_CFG})
    else $error("processor io not routed");
  a_io_addr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_CPU) && req_is_io_in
    |=> rsp_addr_out[16:0] == {$past(io_wrap_address_bit_in), $past(req_addr_in[15:0])})
    else $error("io address translated");
  a_io_noclaim: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in != sad_pkg::SAD_SRC_CPU) && req_is_io_in
    |=> rsp_tgt_out == sad_pkg::SAD_TGT_NONE)
    else $error("foreign io claimed");
  a_huba_4g: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_HUBA) && !req_is_io_in && !req_is_special_in && req_above_4g_in
    |=> rsp_kind_out == ($past(req_write_in) ? sad_pkg::SAD_RSP_DROP : sad_pkg::SAD_RSP_ABORT))
    else $error("above 4 GB not refused");
  a_gfx_nosnoop: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in inside {sad_pkg::SAD_SRC_GFX_FRAME, sad_pkg::SAD_SRC_GFX_PIPE})
    |=> !rsp_snoop_out)
    else $error("graphics cycle snooped");
  a_pipe_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req_valid_in && (req_src_in == sad_pkg::SAD_SRC_GFX_PIPE) && !req_write_in && nxt_flag_set
    |=> invalid_graphics_access_flag_out && rsp_addr_out == sad_pkg::ZERO_ADDR)
    else $error("invalid pipelined read not flagged");
endmodule
`default_nettype wire

// [core/sad_io_route.sv]
// processor i/o routing: config ports, graphics window, second hub window
// assumes i/o address and wrap bit from the processor request
`timescale 1ns/1ps
`default_nettype none
module sad_io_route (
  // request
  input wire logic [15:0] io_addr_in,
  input wire logic io_wrap_address_bit_in,
  // windows
  input wire logic [15:0] gfx_io_window_base_in,
  input wire logic [15:0] gfx_io_window_limit_in,
  input wire logic [15:0] hubb_io_window_base_in,
  input wire logic [15:0] hubb_io_window_limit_in,
  input wire logic hubb_en_in,
  // result
  output sad_pkg::sad_tgt_t tgt_out,
  output logic [16:0] fwd_addr_out
);
  logic gfx_hit;
  logic hubb_hit;
  logic cfg_hit;
  sad_range_cmp #(.W(16)) u_gfx (
    .base_in(gfx_io_window_base_in),
    .limit_in(gfx_io_window_limit_in),
    .en_in(1'b1),
    .addr_in(io_addr_in),
    .hit_out(gfx_hit)
  );
  sad_range_cmp #(.W(16)) u_hubb (
    .base_in(hubb_io_window_base_in),
    .limit_in(hubb_io_window_limit_in),
    .en_in(hubb_en_in),
    .addr_in(io_addr_in),
    .hit_out(hubb_hit)
  );
  // wrapped accesses are never the config ports
  assign cfg_hit = !io_wrap_address_bit_in && ((io_addr_in == sad_pkg::CFG_ADDR_PORT)
    || ((io_addr_in >= sad_pkg::CFG_DATA_PORT) && (io_addr_in <= sad_pkg::CFG_DATA_TOP)));
  // address passes untranslated, wrap bit included
  assign fwd_addr_out = {io_wrap_address_bit_in, io_addr_in};
  always_comb
  begin
    if (cfg_hit)
      tgt_out = sad_pkg::SAD_TGT_CFG;
    else if (gfx_hit)
      tgt_out = sad_pkg::SAD_TGT_GFX;
    else if (hubb_hit)
      tgt_out = sad_pkg::SAD_TGT_HUBB;
    else
      tgt_out = sad_pkg::SAD_TGT_HUBA;
  end
endmodule
`default_nettype wire

// [core/sad_pkg.sv]
// package for the system address decoder: targets, sources, address constants
// assumes a single core clock domain and 32-bit memory addresses
package sad_pkg;
  localparam int ADDR_W = 32;
  localparam int IO_W = 16;
  localparam int PAM_N = 13;
  localparam logic [31:0] COMPAT_LO = 32'h000A0000;
  localparam logic [31:0] COMPAT_HI = 32'h000BFFFF;
  localparam logic [31:0] HIGH_LO = 32'hFFEA0000;
  localparam logic [31:0] HIGH_HI = 32'hFFEBFFFF;
  localparam logic [31:0] HIGH_TO_COMPAT = 32'hFFE00000;
  localparam logic [31:0] PAM_LO = 32'h000C0000;
  localparam logic [31:0] PAM_HI = 32'h000FFFFF;
  localparam logic [31:0] ZERO_ADDR = 32'h00000000;
  localparam int PAM_SHIFT = 14;
  localparam logic [3:0] PAM_BASE_IDX = 4'h0;
  localparam logic [15:0] CFG_ADDR_PORT = 16'h0CF8;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0CFC;
  localparam logic [15:0] CFG_DATA_TOP = 16'h0CFF;
  localparam logic [15:0] IDE_IO_LO = 16'h01F0;
  localparam logic [15:0] IDE_IO_HI = 16'h01F7;

  typedef enum logic [2:0]
  {
    SAD_TGT_NONE = 3'h0,
    SAD_TGT_DRAM = 3'h1,
    SAD_TGT_HUBA = 3'h2,
    SAD_TGT_HUBB = 3'h3,
    SAD_TGT_GFX = 3'h4,
    SAD_TGT_CFG = 3'h5,
    SAD_TGT_ROM = 3'h6
  } sad_tgt_t;

  typedef enum logic [2:0]
  {
    SAD_SRC_CPU = 3'h0,
    SAD_SRC_HUBA = 3'h1,
    SAD_SRC_HUBB = 3'h2,
    SAD_SRC_GFX_FRAME = 3'h3,
    SAD_SRC_GFX_PIPE = 3'h4
  } sad_src_t;

  typedef enum logic [1:0]
  {
    SAD_RSP_OK = 2'h0,
    SAD_RSP_ABORT = 2'h1,
    SAD_RSP_DROP = 2'h2,
    SAD_RSP_UNCLAIMED = 2'h3
  } sad_rsp_t;

  typedef enum logic [1:0]
  {
    SAD_ST_IDLE = 2'b00,
    SAD_ST_DEC = 2'b01,
    SAD_ST_OUT = 2'b11
  } sad_st_t;
endpackage

// [core/sad_range_cmp.sv]
// inclusive base/limit compare used for every window
// assumes combinational use inside the decoder
`timescale 1ns/1ps
`default_nettype none
module sad_range_cmp #(
  parameter int W = 32
) (
  // window
  input wire logic [W-1:0] base_in,
  input wire logic [W-1:0] limit_in,
  input wire logic en_in,
  // probe
  input wire logic [W-1:0] addr_in,
  output logic hit_out
);
  assign hit_out = en_in && (base_in <= addr_in) && (addr_in <= limit_in);
endmodule
`default_nettype wire
